// ===== ahb_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module ahb_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire sd_dma_pkg::ahb_req_t req,
    output sd_dma_pkg::ahb_rsp_t rsp,
    input wire logic slow,
    input wire logic err_en,
    input wire logic [31:0] err_addr
);
    logic [31:0] mem [0:63]; // word store, wraps
    logic pend_r; // data phase open
    logic pwr_r; // open phase is a write
    logic [31:0] pa_r; // open phase address
    logic [31:0] last_r; // last data, inverted when idle
    logic [1:0] wcnt_r; // wait states left
    // answer; outside a read data phase hrdata is the inverted last word, never a repeat
    always_comb begin
        rsp.hready = !(pend_r && wcnt_r != 2'h0);
        rsp.hresp = pend_r && rsp.hready && err_en && pa_r == err_addr;
        rsp.hrdata = (pend_r && !pwr_r) ? mem[pa_r[7:2]] : ~last_r;
    end
    // one word per transfer, optional slow answer
    always @(posedge clk) begin
        if (rst) begin
            pend_r <= 1'b0;
            wcnt_r <= 2'h0;
            last_r <= 32'h0;
        end else if (pend_r && wcnt_r != 2'h0) begin
            wcnt_r <= wcnt_r - 2'h1;
        end else begin
            if (pend_r) last_r <= pwr_r ? req.hwdata : mem[pa_r[7:2]];
            if (pend_r && pwr_r) mem[pa_r[7:2]] <= req.hwdata;
            pend_r <= req.htrans == 2'h2;
            pa_r <= req.haddr;
            pwr_r <= req.hwrite;
            wcnt_r <= slow ? 2'h2 : 2'h0;
        end
    end
endmodule
`default_nettype wire

// ===== sd_dma_consts.svh
`ifndef SD_DMA_CONSTS_SVH
`define SD_DMA_CONSTS_SVH

// descriptor line layout, low word
`define DESC_VALID_BIT 0
`define DESC_END_BIT 1
`define DESC_INT_BIT 2
`define DESC_OP_LSB 4
`define DESC_OP_MSB 5
`define DESC_LEN_LSB 16
`define DESC_LEN_MSB 31

// line operation codes
`define OP_SKIP 2'h0
`define OP_RSVD 2'h1
`define OP_MOVE 2'h2
`define OP_JUMP 2'h3

// address steps in bytes
`define HI_WORD_OFS 32'h0000_0004
`define LINE_STEP 32'h0000_0008
`define WORD_STEP 32'h0000_0004
`define WORD_BYTES 17'h0_0004

// zero length means a full 64 KiB
`define LEN_FULL 17'h1_0000
`define LEN_ZERO 16'h0000

// bus codes
`define HTRANS_IDLE 2'h0
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'b0

// data buffer shape
`define BUF_WIDTH 32
`define BUF_DEPTH 16

`endif

// ===== sd_dma_pkg.sv
`default_nettype none
package sd_dma_pkg;

    // engine states
    typedef enum logic [1:0] {
        halted_state = 2'b00,
        descriptor_read_state = 2'b01,
        pointer_update_state = 2'b10,
        payload_move_state = 2'b11
    } eng_state_t;

    // master request side of the system bus
    typedef struct packed {
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
    } ahb_req_t;

    // slave answer side of the system bus
    typedef struct packed {
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
    } ahb_rsp_t;

    // one-cycle event pulses
    typedef struct packed {
        logic line_done;
        logic table_done;
        logic fault;
    } eng_evt_t;

    // captured on a fault
    typedef struct packed {
        eng_state_t fault_state_capture;
        logic [31:0] fault_address_capture;
    } fault_info_t;

endpackage

`default_nettype wire

// ===== sd_host_descriptor_dma.sv
// Contract
// - skip code 00 lines; 01 reserved
// - code 10 moves data at pointer
// - code 11 jumps to pointer address
// - length zero means 65536 bytes
// - bit 2 raises per-line event
// - bit 1 ends table, raises completion
// - bit 0 clear raises fault, halts
// - halt until command write starts engine
// - read one line, then update pointer
// - jump line loads address, reads again
// - other lines step address, move payload
// - after payload: next line or halt
// - no block-gap pause, no continuation
// - fault records state and address
// - each line is 64 bits
`include "sd_dma_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module sd_host_descriptor_dma (
    input wire logic clk,
    input wire logic rst,
    // command register written: start pulse
    input wire logic cmd_write,
    // descriptor table base address
    input wire logic [31:0] table_base,
    // direction: 1 memory to card, 0 card to memory
    input wire logic dir_to_card,
    // system bus master
    output sd_dma_pkg::ahb_req_t ahb_req,
    input wire sd_dma_pkg::ahb_rsp_t ahb_rsp,
    // card path, memory to card
    output logic card_tx_valid,
    input wire logic card_tx_ready,
    output logic [31:0] card_tx_data,
    // card path, card to memory
    input wire logic card_rx_valid,
    output logic card_rx_ready,
    input wire logic [31:0] card_rx_data,
    // status
    output logic engine_busy,
    output sd_dma_pkg::eng_evt_t events,
    output sd_dma_pkg::fault_info_t fault_info
);

    // whole state of the engine
    typedef struct packed {
        sd_dma_pkg::eng_state_t st; // current engine state
        logic data_ph; // bus data phase pending
        logic hi_word; // fetching upper half
        logic to_card; // direction latched at start
        logic [31:0] sys_addr; // current descriptor address
        logic [31:0] line_lo; // lower half of line
        logic [31:0] line_ptr; // upper half: pointer
        logic [31:0] buf_addr; // payload address
        logic [16:0] remaining; // payload bytes left
        sd_dma_pkg::ahb_req_t ahb; // registered bus request
        logic busy; // engine out of halt
        sd_dma_pkg::eng_evt_t evt; // event pulses
        sd_dma_pkg::fault_info_t fault; // fault capture
    } eng_t;

    eng_t r, n;

    logic bus_idle; // free to launch a transfer
    logic bus_accept; // address phase taken
    logic bus_done; // data phase finished
    logic bus_err; // data phase answered error
    logic fifo_in_valid; // word offered to buffer
    logic fifo_in_ready; // buffer has room
    logic [31:0] fifo_in_data; // word into buffer
    logic fifo_out_valid; // buffer holds a word
    logic fifo_out_ready; // word taken from buffer
    logic [31:0] fifo_out_data; // head word
    logic write_pop; // head taken for a bus write
    logic [1:0] op; // operation code of held line
    logic [16:0] line_bytes; // decoded length

    // byte count after one word, floored at zero
    function automatic logic [16:0] less_word(input logic [16:0] b);
        if (b <= `WORD_BYTES) begin
            less_word = '0;
        end else begin
            less_word = b - `WORD_BYTES;
        end
    endfunction

    // single-transfer bus request
    function automatic sd_dma_pkg::ahb_req_t bus_launch(
        input logic [31:0] addr,
        input logic wr,
        input logic [31:0] wdata
    );
        bus_launch.htrans = `HTRANS_NONSEQ;
        bus_launch.haddr = addr;
        bus_launch.hwrite = wr;
        bus_launch.hsize = `HSIZE_WORD;
        bus_launch.hwdata = wdata;
    endfunction

    // bus handshake decode
    assign bus_idle = !r.data_ph && (r.ahb.htrans == `HTRANS_IDLE);
    assign bus_accept = (r.ahb.htrans == `HTRANS_NONSEQ) && ahb_rsp.hready;
    assign bus_done = r.data_ph && ahb_rsp.hready;
    assign bus_err = bus_done && (ahb_rsp.hresp != `HRESP_OKAY);

    // fields of the held line
    assign op = r.line_lo[`DESC_OP_MSB:`DESC_OP_LSB];
    assign line_bytes = (r.line_lo[`DESC_LEN_MSB:`DESC_LEN_LSB] == `LEN_ZERO)
        ? `LEN_FULL
        : {1'b0, r.line_lo[`DESC_LEN_MSB:`DESC_LEN_LSB]};

    // a memory-bound write launch takes the head word
    assign write_pop = (r.st == sd_dma_pkg::payload_move_state)
        && !r.to_card && bus_idle && fifo_out_valid
        && (r.remaining != '0) && (op == `OP_MOVE);

    // buffer input: memory reads or card words
    assign fifo_in_valid = r.to_card
        ? (r.st == sd_dma_pkg::payload_move_state) && bus_done
          && !bus_err && !r.ahb.hwrite
        : card_rx_valid;
    assign fifo_in_data = r.to_card ? ahb_rsp.hrdata : card_rx_data;

    // buffer output: card or bus writes
    assign fifo_out_ready = r.to_card ? card_tx_ready : write_pop;

    // card path handshakes follow direction
    assign card_tx_valid = r.to_card && fifo_out_valid;
    assign card_tx_data = fifo_out_data;
    assign card_rx_ready = !r.to_card && fifo_in_ready;

    // registered outputs
    assign ahb_req = r.ahb;
    assign engine_busy = r.busy;
    assign events = r.evt;
    assign fault_info = r.fault;

    // data buffer between bus and card
    word_fifo #(
        .WIDTH(`BUF_WIDTH),
        .DEPTH(`BUF_DEPTH)
    ) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // engine next-state logic
    always_comb begin
        n = r;
        n.evt = '0;
        // address phase taken: drop request, await data
        if (bus_accept) begin
            n.ahb.htrans = `HTRANS_IDLE;
            n.data_ph = 1'b1;
        end
        if (bus_done) begin
            n.data_ph = 1'b0;
        end
        unique case (r.st)
            // wait for a command write
            sd_dma_pkg::halted_state: begin
                n.busy = 1'b0;
                if (cmd_write) begin
                    n.st = sd_dma_pkg::descriptor_read_state;
                    n.sys_addr = table_base;
                    n.to_card = dir_to_card;
                    n.hi_word = 1'b0;
                    n.busy = 1'b1;
                end
            end
            // fetch both halves of one 64-bit line
            sd_dma_pkg::descriptor_read_state: begin
                if (bus_idle) begin
                    n.ahb = bus_launch(r.hi_word
                        ? r.sys_addr + `HI_WORD_OFS : r.sys_addr,
                        1'b0, '0);
                end
                if (bus_done && !bus_err) begin
                    if (!r.hi_word) begin
                        n.line_lo = ahb_rsp.hrdata;
                        n.hi_word = 1'b1;
                    end else begin
                        n.line_ptr = ahb_rsp.hrdata;
                        n.hi_word = 1'b0;
                        n.st = sd_dma_pkg::pointer_update_state;
                    end
                end
            end
            // decide next address from the held line
            sd_dma_pkg::pointer_update_state: begin
                if (!r.line_lo[`DESC_VALID_BIT] || op == `OP_RSVD) begin
                    // invalid or reserved line: fault
                    n.evt.fault = 1'b1;
                    n.fault.fault_state_capture = r.st;
                    n.fault.fault_address_capture = r.sys_addr;
                    n.st = sd_dma_pkg::halted_state;
                end else if (op == `OP_JUMP) begin
                    n.sys_addr = r.line_ptr;
                    n.st = sd_dma_pkg::descriptor_read_state;
                end else begin
                    n.sys_addr = r.sys_addr + `LINE_STEP;
                    n.buf_addr = r.line_ptr;
                    n.remaining = line_bytes;
                    n.st = sd_dma_pkg::payload_move_state;
                end
            end
            // move the line's payload, runs to the end unpaused
            sd_dma_pkg::payload_move_state: begin
                if (op != `OP_MOVE || (r.remaining == '0 && bus_idle)) begin
                    // line finished, skip lines move nothing
                    n.evt.line_done = r.line_lo[`DESC_INT_BIT];
                    if (r.line_lo[`DESC_END_BIT]) begin
                        n.evt.table_done = 1'b1;
                        n.st = sd_dma_pkg::halted_state;
                    end else begin
                        n.st = sd_dma_pkg::descriptor_read_state;
                    end
                end else begin
                    // launch one word when the buffer allows
                    if (r.to_card) begin
                        if (bus_idle && fifo_in_ready
                            && r.remaining != '0) begin
                            n.ahb = bus_launch(r.buf_addr, 1'b0, '0);
                        end
                    end else if (write_pop) begin
                        n.ahb = bus_launch(r.buf_addr, 1'b1,
                            fifo_out_data);
                    end
                    // word completed on the bus
                    if (bus_done && !bus_err) begin
                        n.buf_addr = r.buf_addr + `WORD_STEP;
                        n.remaining = less_word(r.remaining);
                    end
                end
            end
        endcase
        // bus error in any active state halts with capture
        if (bus_err) begin
            n.evt.fault = 1'b1;
            n.evt.line_done = 1'b0;
            n.evt.table_done = 1'b0;
            n.fault.fault_state_capture = r.st;
            n.fault.fault_address_capture = r.sys_addr;
            n.st = sd_dma_pkg::halted_state;
            n.hi_word = 1'b0;
        end
    end

    // state register, halted after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
            r.st <= sd_dma_pkg::halted_state;
            r.ahb.hsize <= `HSIZE_WORD;
        end else begin
            r <= n;
        end
    end

endmodule

`default_nettype wire

// ===== sd_host_descriptor_dma_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sd_host_descriptor_dma_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_write,
    input wire logic [31:0] table_base,
    input wire sd_dma_pkg::ahb_req_t ahb_req,
    input wire sd_dma_pkg::ahb_rsp_t ahb_rsp,
    input wire logic engine_busy,
    input wire sd_dma_pkg::eng_evt_t events,
    input wire sd_dma_pkg::fault_info_t fault_info
);
    // one clock domain, reset disables everything
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_start_busy: assert property (
        !engine_busy && cmd_write |=> engine_busy) else $error("no start");
    a_no_self_start: assert property (
        !engine_busy && !cmd_write |=> !engine_busy) else $error("self start");
    a_first_fetch: assert property (
        !engine_busy && cmd_write |=> ##1 ahb_req.htrans == 2'h2
        && ahb_req.haddr == $past(table_base, 2)) else $error("bad fetch");
    a_word_size: assert property (
        ahb_req.htrans == 2'h2 |-> ahb_req.hsize == 3'h2) else $error("size");
    a_req_stands: assert property (
        ahb_req.htrans == 2'h2 && !ahb_rsp.hready |=> ahb_req.htrans == 2'h2
        && $stable(ahb_req.haddr)) else $error("request dropped");
    a_idle_gap: assert property (
        ahb_req.htrans == 2'h2 && ahb_rsp.hready |=> ahb_req.htrans == 2'h0)
        else $error("no idle gap");
    a_done_pulse: assert property (
        events.table_done |=> !events.table_done) else $error("long pulse");
    a_done_halts: assert property (
        events.table_done |-> ##[0:2] !engine_busy) else $error("no halt");
    a_fault_idle: assert property (
        events.fault |=> (ahb_req.htrans == 2'h0) [*4]) else $error("runs on");
    a_fault_state: assert property (
        events.fault |-> ##[0:1] fault_info.fault_state_capture
        != sd_dma_pkg::halted_state) else $error("state not captured");
endmodule
bind sd_host_descriptor_dma sd_host_descriptor_dma_assertions u_chk (
    .clk(clk),
    .rst(rst),
    .cmd_write(cmd_write),
    .table_base(table_base),
    .ahb_req(ahb_req),
    .ahb_rsp(ahb_rsp),
    .engine_busy(engine_busy),
    .events(events),
    .fault_info(fault_info)
);
`default_nettype wire

// ===== sd_host_descriptor_dma_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module sd_host_descriptor_dma_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_write = 1'b0;
    logic [31:0] table_base = 32'h0;
    logic dir_to_card = 1'b1;
    sd_dma_pkg::ahb_req_t ahb_req;
    sd_dma_pkg::ahb_rsp_t ahb_rsp;
    logic card_tx_valid;
    logic card_tx_ready = 1'b1;
    logic [31:0] card_tx_data;
    logic card_rx_valid = 1'b0;
    logic card_rx_ready;
    logic [31:0] card_rx_data = 32'h0;
    logic engine_busy;
    sd_dma_pkg::eng_evt_t events;
    sd_dma_pkg::fault_info_t fault_info;
    logic slow = 1'b0;
    logic err_en = 1'b0;
    logic [31:0] err_addr = 32'h0;
    logic stall = 1'b0;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int n_tx = 0;
    int n_line = 0;
    int n_end = 0;
    int n_flt = 0;
    logic [31:0] tx_q [$];
    always #25 clk = ~clk;
    sd_host_descriptor_dma u_dut (.clk(clk), .rst(rst), .cmd_write(cmd_write),
        .table_base(table_base), .dir_to_card(dir_to_card), .ahb_req(ahb_req),
        .ahb_rsp(ahb_rsp), .card_tx_valid(card_tx_valid),
        .card_tx_ready(card_tx_ready), .card_tx_data(card_tx_data),
        .card_rx_valid(card_rx_valid), .card_rx_ready(card_rx_ready),
        .card_rx_data(card_rx_data), .engine_busy(engine_busy),
        .events(events), .fault_info(fault_info));
    ahb_mem_model u_mem (.clk(clk), .rst(rst), .req(ahb_req), .rsp(ahb_rsp),
        .slow(slow), .err_en(err_en), .err_addr(err_addr));
    // card side: stalling sink, one-word source, event counts, watchdog
    always @(posedge clk) begin
        cycles++;
        card_tx_ready <= stall ? ~card_tx_ready : 1'b1;
        if (card_tx_valid && card_tx_ready) begin
            n_tx++;
            tx_q.push_back(card_tx_data);
        end
        if (card_rx_valid && card_rx_ready) begin
            card_rx_valid <= 1'b0;
            card_rx_data <= ~card_rx_data;
        end
        n_line += int'(events.line_done);
        n_end += int'(events.table_done);
        n_flt += int'(events.fault);
        if (cycles == 90000) begin
            errors++;
            test_done();
        end
    end
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // descriptor low word
    function automatic logic [31:0] ln(input logic [15:0] len,
        input logic [1:0] op, input logic i, input logic e, input logic v);
        return {len, 10'h0, op, 1'b0, i, e, v};
    endfunction
    // start one table and wait until the engine halts
    task automatic run(input logic [31:0] base, input logic dir);
        n_tx = 0;
        n_line = 0;
        n_end = 0;
        n_flt = 0;
        tx_q.delete();
        table_base <= base;
        dir_to_card <= dir;
        cmd_write <= 1'b1;
        @(posedge clk);
        cmd_write <= 1'b0;
        repeat (2) @(posedge clk);
        while (engine_busy !== 1'b0) @(posedge clk);
        // quiet gap after any event stands in for the abort sequence
        repeat (40) @(posedge clk);
    endtask
    task automatic t_move;
        u_mem.mem[0] = ln(16'h0008, 2'h2, 1'b1, 1'b0, 1'b1);
        u_mem.mem[1] = 32'h0000_0080;
        u_mem.mem[2] = ln(16'h0004, 2'h0, 1'b0, 1'b1, 1'b1);
        u_mem.mem[32] = 32'h1234_5678;
        u_mem.mem[33] = 32'h9ABC_DEF0;
        stall <= 1'b1;
        run(32'h0, 1'b1);
        cmp(n_tx, 32'h2, "word count");
        cmp(tx_q[0], 32'h1234_5678, "first word");
        cmp(tx_q[1], 32'h9ABC_DEF0, "second word");
        cmp(n_line, 32'h1, "line events");
        cmp(n_end, 32'h1, "table done");
        $display("test move done");
    endtask
    task automatic t_jump;
        u_mem.mem[8] = ln(16'h0000, 2'h3, 1'b0, 1'b0, 1'b1);
        u_mem.mem[9] = 32'h0000_0040;
        u_mem.mem[16] = ln(16'h0004, 2'h2, 1'b1, 1'b1, 1'b1);
        u_mem.mem[17] = 32'h0000_00A0;
        stall <= 1'b0;
        card_rx_data <= 32'hCAFE_0001;
        card_rx_valid <= 1'b1;
        run(32'h20, 1'b0);
        cmp(u_mem.mem[40], 32'hCAFE_0001, "stored word");
        cmp(n_line, 32'h1, "line events");
        cmp(n_end, 32'h1, "table done");
        $display("test jump done");
    endtask
    task automatic t_fault;
        for (int k = 0; k < 2; k++) begin
            u_mem.mem[24] = k == 0 ? ln(16'h0004, 2'h2, 1'b0, 1'b1, 1'b0)
                                   : ln(16'h0004, 2'h1, 1'b0, 1'b1, 1'b1);
            u_mem.mem[25] = 32'h0000_0080;
            run(32'h60, 1'b1);
            cmp(n_flt, 32'h1, "fault events");
            cmp(n_tx, 32'h0, "no payload");
            cmp(fault_info.fault_state_capture, 32'h2, "fault state");
            cmp(fault_info.fault_address_capture, 32'h60, "fault addr");
        end
        $display("test fault done");
    endtask
    task automatic t_buserr;
        u_mem.mem[28] = ln(16'h0004, 2'h2, 1'b0, 1'b1, 1'b1);
        u_mem.mem[29] = 32'h0000_00B0;
        slow <= 1'b1;
        err_en <= 1'b1;
        err_addr <= 32'h0000_00B0;
        run(32'h70, 1'b1);
        cmp(n_flt, 32'h1, "fault events");
        cmp(n_end, 32'h0, "no completion");
        cmp(fault_info.fault_state_capture, 32'h3, "fault state");
        cmp(fault_info.fault_address_capture, 32'h78, "fault addr");
        slow <= 1'b0;
        err_en <= 1'b0;
        $display("test bus error done");
    endtask
    task automatic t_full;
        u_mem.mem[0] = ln(16'h0000, 2'h2, 1'b0, 1'b1, 1'b1);
        u_mem.mem[1] = 32'h0000_0080;
        run(32'h0, 1'b1);
        cmp(n_tx, 32'h4000, "full length words");
        $display("test full length done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_move();
        t_jump();
        t_fault();
        t_buserr();
        t_full();
        test_done();
    end
endmodule
`default_nettype wire

// ===== word_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    // whole state of the buffer
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } fifo_t;

    fifo_t r, n;
    logic push; // word accepted this cycle
    logic pop; // word leaves this cycle

    // honest flags from the occupancy count
    assign in_ready = (r.count != (AW + 1)'(DEPTH));
    assign out_valid = (r.count != '0);
    assign out_data = r.mem[r.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // next state: write, read, count
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wr_ptr] = in_data;
            n.wr_ptr = r.wr_ptr + 1'b1;
        end
        if (pop) begin
            n.rd_ptr = r.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            n.count = r.count + 1'b1;
        end else if (pop && !push) begin
            n.count = r.count - 1'b1;
        end
    end

    // state register, pointers cleared on reset
    always_ff @(posedge clk) begin
        if (rst) begin
            r.wr_ptr <= '0;
            r.rd_ptr <= '0;
            r.count <= '0;
            r.mem <= n.mem;
        end else begin
            r <= n;
        end
    end

endmodule

`default_nettype wire
